// *** rtl/phy_link_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "phy_link_consts.svh"

module phy_link_mode_control #(
	parameter int unsigned ADDR_W      = 12,
	parameter int unsigned BREAK_CYCLES = `BREAK_LINK_MS * `CLK_MHZ * 1000
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              flp_seen,
	input  wire logic              mlt3_seen,
	input  wire logic              nlp_seen,
	input  wire logic              pd_fault_in,
	input  wire logic              lcw_valid,
	input  wire logic [15:0]       lcw_data,
	input  wire logic              signal_lost,
	input  wire logic              tx_active,
	input  wire logic              rx_active,
	input  wire logic              partner_crossed,
	input  wire logic              crossover_enable_pin,
	input  wire logic              pair_swap_select_pin,
	output logic                   link_up,
	output logic                   speed_100,
	output logic                   full_duplex,
	output logic                   traffic_halt,
	output logic                   crs,
	output logic                   collision,
	output logic                   lost_carrier,
	output logic                   twisted_pair_swap
);

	// ==================================================================
	// Constants and state.
	localparam logic [27:0] BREAK_LAST = 28'(BREAK_CYCLES - 1);

	phy_link_pkg::link_s st_r;
	phy_link_pkg::link_s st_nxt;

	logic [4:0]  reg_idx;
	logic        addr_ok;
	logic        wr_en;
	logic        rd_en;
	logic [3:0]  common;
	logic        xover_auto;

	// ==================================================================
	// Bus decode: a transfer completes on the edge where pready is high.
	assign reg_idx = paddr[6:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && ((paddr >> 7) == '0);
	assign wr_en   = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
	assign rd_en   = psel && penable && st_r.pready && !pwrite && !st_r.pslverr;
	assign common  = st_r.adv & lcw_data[`ABIL_HI_BIT:`ABIL_LO_BIT];
	assign xover_auto = st_r.xover_en && crossover_enable_pin;

	// ==================================================================
	// Next-state logic for registers, link state and line signals.
	always_comb
	begin
		st_nxt = st_r;

		// Answer in the first access cycle with registered data.
		st_nxt.pready  = psel && !penable;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata  = 32'h0;
		if (psel && !penable)
		begin
			if (!addr_ok)
				st_nxt.pslverr = 1'b1;
			else if (!pwrite)
			begin
				unique case (reg_idx)
					`REG_CTRL_IDX:
					begin
						st_nxt.prdata[`CTRL_SPEED_BIT]   = st_r.speed_sel;
						st_nxt.prdata[`CTRL_AN_EN_BIT]   = st_r.an_en;
						st_nxt.prdata[`CTRL_RESTART_BIT] = st_r.restart;
						st_nxt.prdata[`CTRL_DUPLEX_BIT]  = st_r.duplex_sel;
					end
					`REG_STAT_IDX:
						st_nxt.prdata[6:0] = {st_r.pair_swap, st_r.state, st_r.halt,
							st_r.full_duplex, st_r.speed_100, st_r.link_up};
					`REG_ADV_IDX:
						st_nxt.prdata[8:0] = {st_r.adv, `ADV_SELECTOR};
					`REG_LPA_IDX:
						st_nxt.prdata[15:0] = st_r.lp_ability;
					`REG_EXP_IDX:
					begin
						st_nxt.prdata[`EXP_LP_AN_BIT]    = st_r.lp_an_able;
						st_nxt.prdata[`EXP_PD_FAULT_BIT] = st_r.pd_fault;
					end
					`REG_MODE_IDX:
						st_nxt.prdata[`MODE_XOVER_BIT] = st_r.xover_en;
					default:
						st_nxt.pslverr = 1'b1;
				endcase
			end
			else if (!(reg_idx inside {`REG_CTRL_IDX, `REG_STAT_IDX, `REG_ADV_IDX,
				`REG_LPA_IDX, `REG_EXP_IDX, `REG_MODE_IDX}))
				st_nxt.pslverr = 1'b1;
		end

		// Register writes; the advert write does not touch the link state.
		if (wr_en && reg_idx == `REG_CTRL_IDX)
		begin
			st_nxt.speed_sel  = pwdata[`CTRL_SPEED_BIT];
			st_nxt.an_en      = pwdata[`CTRL_AN_EN_BIT];
			st_nxt.duplex_sel = pwdata[`CTRL_DUPLEX_BIT];
			if (pwdata[`CTRL_RESTART_BIT])
				st_nxt.restart = 1'b1;
		end
		if (wr_en && reg_idx == `REG_ADV_IDX)
			st_nxt.adv = pwdata[`ABIL_HI_BIT:`ABIL_LO_BIT];
		if (wr_en && reg_idx == `REG_MODE_IDX)
			st_nxt.xover_en = pwdata[`MODE_XOVER_BIT];

		// The fault flag clears on read of register 6.
		if (rd_en && reg_idx == `REG_EXP_IDX)
			st_nxt.pd_fault = 1'b0;

		// Link state machine.
		st_nxt.halt = 1'b0;
		if (!st_r.an_en)
		begin
			// Forced mode uses the manual bits.
			st_nxt.state       = phy_link_pkg::ST_FORCED;
			st_nxt.restart     = 1'b0;
			st_nxt.link_up     = !signal_lost;
			st_nxt.speed_100   = st_r.speed_sel;
			st_nxt.full_duplex = st_r.duplex_sel;
		end
		else if (st_r.state == phy_link_pkg::ST_FORCED)
		begin
			st_nxt.state   = phy_link_pkg::ST_NEG;
			st_nxt.link_up = 1'b0;
		end
		else if (st_r.restart)
		begin
			// Accept the restart: drop the link and start the break wait.
			st_nxt.state   = phy_link_pkg::ST_BREAK;
			st_nxt.restart = wr_en && reg_idx == `REG_CTRL_IDX &&
				pwdata[`CTRL_RESTART_BIT];
			st_nxt.timer   = 28'h0;
			st_nxt.link_up = 1'b0;
			st_nxt.halt    = 1'b1;
		end
		else
		begin
			unique case (st_r.state)
				phy_link_pkg::ST_BREAK:
				begin
					st_nxt.halt  = 1'b1;
					st_nxt.timer = st_r.timer + 28'h1;
					if (st_r.timer == BREAK_LAST)
					begin
						st_nxt.state = phy_link_pkg::ST_NEG;
						st_nxt.halt  = 1'b0;
					end
				end
				phy_link_pkg::ST_NEG:
				begin
					if (pd_fault_in)
						st_nxt.pd_fault = 1'b1;
					if (lcw_valid)
					begin
						st_nxt.lp_ability = lcw_data;
						st_nxt.lp_an_able = 1'b1;
						if (common != 4'h0)
						begin
							// Resolution ignores the manual bits.
							st_nxt.state       = phy_link_pkg::ST_LINK;
							st_nxt.link_up     = 1'b1;
							st_nxt.speed_100   = common[3] || common[2];
							st_nxt.full_duplex = common[3] ||
								(!common[2] && common[1]);
						end
					end
					else if (!flp_seen && (mlt3_seen || nlp_seen))
					begin
						st_nxt.state       = phy_link_pkg::ST_LINK;
						st_nxt.link_up     = 1'b1;
						st_nxt.speed_100   = mlt3_seen;
						st_nxt.full_duplex = 1'b0;
						st_nxt.lp_an_able  = 1'b0;
						st_nxt.lp_ability  = 16'h0;
						st_nxt.lp_ability[`LPA_100HD_BIT] = mlt3_seen;
						st_nxt.lp_ability[`LPA_10HD_BIT]  = !mlt3_seen;
					end
				end
				phy_link_pkg::ST_LINK:
				begin
					if (signal_lost)
					begin
						st_nxt.state   = phy_link_pkg::ST_NEG;
						st_nxt.link_up = 1'b0;
					end
				end
				phy_link_pkg::ST_FORCED:
					st_nxt.state = phy_link_pkg::ST_NEG;
			endcase
		end

		// Carrier sense and collision per duplex mode.
		if (st_r.halt)
		begin
			st_nxt.crs       = 1'b0;
			st_nxt.collision = 1'b0;
		end
		else if (st_r.full_duplex)
		begin
			st_nxt.crs       = rx_active && !tx_active;
			st_nxt.collision = 1'b0;
		end
		else
		begin
			st_nxt.crs       = tx_active || rx_active;
			st_nxt.collision = tx_active && rx_active;
		end
		st_nxt.lost_carrier = tx_active && !st_r.crs && !st_r.full_duplex;

		// Pair assignment.
		st_nxt.pair_swap = xover_auto ? partner_crossed : pair_swap_select_pin;
	end

	// ==================================================================
	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r            <= '0;
			st_r.state      <= phy_link_pkg::ST_NEG;
			st_r.an_en      <= `RST_AN_EN;
			st_r.speed_sel  <= `RST_SPEED;
			st_r.duplex_sel <= `RST_DUPLEX;
			st_r.adv        <= `RST_ADV;
			st_r.xover_en   <= `RST_XOVER;
		end
		else
			st_r <= st_nxt;
	end

	// ==================================================================
	// Outputs straight from the state register.
	assign pready            = st_r.pready;
	assign prdata            = st_r.prdata;
	assign pslverr           = st_r.pslverr;
	assign link_up           = st_r.link_up;
	assign speed_100         = st_r.speed_100;
	assign full_duplex       = st_r.full_duplex;
	assign traffic_halt      = st_r.halt;
	assign crs               = st_r.crs;
	assign collision         = st_r.collision;
	assign lost_carrier      = st_r.lost_carrier;
	assign twisted_pair_swap = st_r.pair_swap;

	// ==================================================================
	// Assertions and covers.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic neg_ok;
	assign neg_ok = st_r.state == phy_link_pkg::ST_NEG && st_r.an_en && !st_r.restart;

	AST_PD_HALF: assert property (
		neg_ok && !lcw_valid && !flp_seen && mlt3_seen
		|=> link_up && speed_100 && !full_duplex && !st_r.lp_an_able
		&& st_r.lp_ability[`LPA_100HD_BIT])
		else $error("parallel detect did not form a 100M half-duplex link");
	AST_PD_NLP: assert property (
		neg_ok && !lcw_valid && !flp_seen && !mlt3_seen && nlp_seen
		|=> link_up && !speed_100 && !full_duplex && st_r.lp_ability[`LPA_10HD_BIT])
		else $error("parallel detect did not form a 10M half-duplex link");
	AST_PD_FAULT: assert property (
		neg_ok && pd_fault_in |=> st_r.pd_fault)
		else $error("parallel detect fault not flagged");
	AST_LCW_STORE: assert property (
		neg_ok && lcw_valid |=> st_r.lp_ability == $past(lcw_data) && st_r.lp_an_able)
		else $error("partner code word not stored");
	AST_RESTART: assert property (
		st_r.restart && st_r.an_en && st_r.state != phy_link_pkg::ST_FORCED
		&& !wr_en |=> st_r.state == phy_link_pkg::ST_BREAK && traffic_halt
		&& !st_r.restart && !link_up)
		else $error("restart not accepted");
	AST_BREAK_END: assert property (
		st_r.state == phy_link_pkg::ST_BREAK && st_r.an_en && !st_r.restart
		&& st_r.timer == BREAK_LAST |=> st_r.state == phy_link_pkg::ST_NEG && !traffic_halt)
		else $error("break wait did not end on time");
	AST_LINK_LOSS: assert property (
		st_r.state == phy_link_pkg::ST_LINK && st_r.an_en && !st_r.restart && signal_lost
		|=> st_r.state == phy_link_pkg::ST_NEG && !link_up)
		else $error("signal loss did not restart negotiation");
	AST_ADV_KEEP: assert property (
		st_r.state == phy_link_pkg::ST_LINK && st_r.an_en && !st_r.restart && !signal_lost
		&& wr_en && reg_idx == `REG_ADV_IDX |=> st_r.state == phy_link_pkg::ST_LINK)
		else $error("advert write disturbed the link");
	AST_FORCED: assert property (
		!st_r.an_en ##1 !st_r.an_en
		|-> speed_100 == $past(st_r.speed_sel) && full_duplex == $past(st_r.duplex_sel))
		else $error("forced mode not following manual bits");
	AST_HALF_COL: assert property (
		!st_r.halt && !st_r.full_duplex && tx_active && rx_active |=> crs && collision)
		else $error("half duplex collision missing");
	AST_FULL_TX: assert property (
		!st_r.halt && st_r.full_duplex && tx_active |=> !crs && !collision)
		else $error("full duplex transmit raised carrier sense");
	AST_FULL_NOLC: assert property (
		st_r.full_duplex |=> !lost_carrier)
		else $error("lost carrier reported in full duplex");
	AST_SWAP_PIN: assert property (
		!(st_r.xover_en && crossover_enable_pin) |=> twisted_pair_swap == $past(pair_swap_select_pin))
		else $error("pair select pin not followed");

	// Restart latch, negotiation priority, flag clearing and line status.
	AST_RESTART_SET: assert property (
		st_r.an_en && wr_en && reg_idx == `REG_CTRL_IDX && pwdata[`CTRL_RESTART_BIT]
		|=> st_r.restart)
		else $error("restart request not latched");
	AST_FLP_WAIT: assert property (
		neg_ok && !lcw_valid && flp_seen |=> st_r.state == phy_link_pkg::ST_NEG && !link_up)
		else $error("negotiating partner taken for a legacy one");
	AST_NEG_FULL: assert property (
		neg_ok && lcw_valid && common[3] |=> link_up && speed_100 && full_duplex)
		else $error("highest common ability not chosen");
	AST_PD_RDCLR: assert property (
		rd_en && reg_idx == `REG_EXP_IDX && !(neg_ok && pd_fault_in) |=> !st_r.pd_fault)
		else $error("fault flag not cleared by its read");
	AST_HALT_QUIET: assert property (
		st_r.halt |=> !crs && !collision)
		else $error("line status active during break wait");
	AST_HALF_CRS: assert property (
		!st_r.halt && !st_r.full_duplex && (tx_active || rx_active) |=> crs)
		else $error("half duplex carrier sense missing");
	AST_FULL_RX: assert property (
		!st_r.halt && st_r.full_duplex && rx_active && !tx_active |=> crs && !collision)
		else $error("full duplex receive carrier sense missing");
	AST_HALF_LC: assert property (
		!st_r.full_duplex && tx_active && !crs |=> lost_carrier)
		else $error("lost carrier not reported in half duplex");
	AST_SWAP_AUTO: assert property (
		st_r.xover_en && crossover_enable_pin |=> twisted_pair_swap == $past(partner_crossed))
		else $error("automatic pair assignment not followed");

	// Covers of the main scenarios.
	COV_PD: cover property (neg_ok && !lcw_valid && !flp_seen && mlt3_seen);
	COV_NEG_LINK: cover property (neg_ok && lcw_valid ##1 link_up);
	COV_BREAK: cover property (st_r.state == phy_link_pkg::ST_BREAK ##1
		st_r.state == phy_link_pkg::ST_NEG);
	COV_FORCED: cover property (!st_r.an_en ##1 link_up);
	COV_COLLISION: cover property (collision && !full_duplex);

endmodule : phy_link_mode_control

`default_nettype wire

// *** rtl/phy_link_consts.svh ***
`ifndef PHY_LINK_CONSTS_SVH
`define PHY_LINK_CONSTS_SVH

// =====================================================================
// Register indexes; the byte address is four times the index.
`define REG_CTRL_IDX      5'd0
`define REG_STAT_IDX      5'd1
`define REG_ADV_IDX       5'd4
`define REG_LPA_IDX       5'd5
`define REG_EXP_IDX       5'd6
`define REG_MODE_IDX      5'd27

// =====================================================================
// Field positions.
`define CTRL_SPEED_BIT    13
`define CTRL_AN_EN_BIT    12
`define CTRL_RESTART_BIT  9
`define CTRL_DUPLEX_BIT   8
`define ABIL_LO_BIT       5
`define ABIL_HI_BIT       8
`define EXP_LP_AN_BIT     0
`define EXP_PD_FAULT_BIT  4
`define MODE_XOVER_BIT    15
`define LPA_100HD_BIT     7
`define LPA_10HD_BIT      5

// =====================================================================
// Reset values.
`define RST_AN_EN         1'b1
`define RST_SPEED         1'b1
`define RST_DUPLEX        1'b0
`define RST_ADV           4'hf
`define RST_XOVER         1'b1
`define ADV_SELECTOR      5'h01

// =====================================================================
// Timing: break-link wait in ms and the clock rate in MHz.
`define BREAK_LINK_MS     1200
`define CLK_MHZ           200

`endif

// *** rtl/phy_link_pkg.sv ***
`default_nettype none

package phy_link_pkg;

	// ==================================================================
	// Link configuration states.
	typedef enum logic [1:0]
	{
		ST_FORCED = 2'b00,
		ST_BREAK  = 2'b01,
		ST_NEG    = 2'b10,
		ST_LINK   = 2'b11
	} link_state_e;

	// ==================================================================
	// Whole state of the block.
	typedef struct packed
	{
		link_state_e state;
		logic [27:0] timer;
		logic        an_en;
		logic        restart;
		logic        speed_sel;
		logic        duplex_sel;
		logic [3:0]  adv;
		logic [15:0] lp_ability;
		logic        lp_an_able;
		logic        pd_fault;
		logic        xover_en;
		logic        link_up;
		logic        speed_100;
		logic        full_duplex;
		logic        halt;
		logic        crs;
		logic        collision;
		logic        lost_carrier;
		logic        pair_swap;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} link_s;

endpackage : phy_link_pkg

`default_nettype wire

// *** verif/link_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Remote partner: kind 0 silent, 1 legacy 100M, 2 legacy 10M, 3 negotiating.
module link_partner_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [1:0]  mode,
	input  wire logic        cut,
	input  wire logic        send,
	input  wire logic [15:0] word,
	output logic             flp_seen,
	output logic             mlt3_seen,
	output logic             nlp_seen,
	output logic             lcw_valid,
	output logic [15:0]      lcw_data,
	output logic             signal_lost
);
	// Line indications follow the partner kind a cycle later; a cut cable shows nothing.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flp_seen    <= 1'b0;
			mlt3_seen   <= 1'b0;
			nlp_seen    <= 1'b0;
			lcw_valid   <= 1'b0;
			signal_lost <= 1'b1;
			lcw_data    <= 16'h5a5a;
		end
		else
		begin
			flp_seen    <= !cut && mode == 2'd3;
			mlt3_seen   <= !cut && mode == 2'd1;
			nlp_seen    <= !cut && mode == 2'd2;
			lcw_valid   <= !cut && mode == 2'd3 && send;
			signal_lost <= cut || mode == 2'd0;
			lcw_data    <= send ? word : ~lcw_data; // Stale words toggle so they are useless.
		end
	end
endmodule : link_partner_model

`default_nettype wire

// *** verif/phy_link_mode_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module phy_link_mode_control_tb_top;
	localparam int BRK = 20;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic        pd_fault_in, tx_active, rx_active, partner_crossed;
	logic        crossover_enable_pin, pair_swap_select_pin, cut, send;
	logic        flp_seen, mlt3_seen, nlp_seen, lcw_valid, signal_lost;
	logic [15:0] lcw_data, word;
	logic [1:0]  mode;
	logic        link_up, speed_100, full_duplex, traffic_halt;
	logic        crs, collision, lost_carrier, twisted_pair_swap;
	int          num_errors, n_tests, n, i, a, p, x, c;

	phy_link_mode_control #(.ADDR_W(12), .BREAK_CYCLES(BRK)) DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .flp_seen, .mlt3_seen, .nlp_seen, .pd_fault_in, .lcw_valid, .lcw_data,
		.signal_lost, .tx_active, .rx_active, .partner_crossed, .crossover_enable_pin,
		.pair_swap_select_pin, .link_up, .speed_100, .full_duplex, .traffic_halt, .crs,
		.collision, .lost_carrier, .twisted_pair_swap
	);

	link_partner_model partner (
		.pclk, .presetn, .mode, .cut, .send, .word, .flp_seen, .mlt3_seen, .nlp_seen,
		.lcw_valid, .lcw_data, .signal_lost
	);

	// ================================================================
	// Clock and watchdog.
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial
	begin
		#200000;
		num_errors++;
		report_and_stop();
	end

	// ================================================================
	// Shared tasks.
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] w);
		n_tests++;
		if (g !== w)
		begin
			num_errors++;
			$display("ERROR %0t: word %h expected %h", $time, g, w);
		end
	endtask : chk_reg

	task automatic chk_bit(input logic g, input logic w);
		n_tests++;
		if (g !== w)
		begin
			num_errors++;
			$display("ERROR %0t: line %b expected %b", $time, g, w);
		end
	endtask : chk_bit

	// One APB transfer; the request holds until pready is seen high at an edge.
	// A slave that never answers is caught by the watchdog.
	task automatic apb(input logic w, input logic [4:0] idx, input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {5'h00, idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_up;
		n = 0;
		while (link_up !== 1'b1 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100) num_errors++;
		repeat (2) @(posedge pclk);
	endtask : wait_up

	// Restart with line activity present; traffic must stay stopped for the break wait.
	task automatic restart(input logic [31:0] cw);
		apb(1'b1, 5'd0, cw);
		tx_active <= 1'b1;
		rx_active <= 1'b1;
		repeat (2) @(posedge pclk);
		chk_bit(traffic_halt, 1'b1);
		chk_bit(crs | collision | link_up, 1'b0);
		apb(1'b0, 5'd0, 32'h0);
		chk_reg(d & 32'h200, 32'h0);
		tx_active <= 1'b0;
		rx_active <= 1'b0;
		n = 0;
		while (traffic_halt === 1'b1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		chk_bit(n + 6 >= BRK - 1 && n + 6 <= BRK + 3, 1'b1);
	endtask : restart

	// Walk every transmit and receive combination in the present duplex.
	task automatic crs_check(input logic fd);
		int k;
		for (k = 0; k < 4; k++)
		begin
			tx_active <= k[1];
			rx_active <= k[0];
			repeat (3) @(posedge pclk);
			chk_bit(crs, fd ? (k[0] & !k[1]) : (k[0] | k[1]));
			chk_bit(collision, !fd & k[0] & k[1]);
			if (fd) chk_bit(lost_carrier, 1'b0);
		end
		tx_active <= 1'b0;
		rx_active <= 1'b0;
	endtask : crs_check

	// ================================================================
	// Main sequence.
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pd_fault_in} = '0;
		{tx_active, rx_active, partner_crossed, pair_swap_select_pin, cut, send} = '0;
		{crossover_enable_pin, word, mode} = {1'b1, 16'h0, 2'd0};
		num_errors = 0;
		n_tests = 0;
		x = $urandom(18525);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 5'd0, 32'h0);
		chk_reg(d, 32'h3000);
		apb(1'b0, 5'd4, 32'h0);
		chk_reg(d, 32'h01e1);
		apb(1'b0, 5'd27, 32'h0);
		chk_reg(d, 32'h8000);
		apb(1'b0, 5'd2, 32'h0);
		chk_reg({d[31:1], e}, 32'h1);
		$display("test reset done");
		x = $urandom_range(1, 0);
		partner_crossed <= x[0];
		mode <= 2'd1;
		wait_up();
		apb(1'b0, 5'd1, 32'h0);
		chk_reg(d & 32'h7f, 32'h33 | (x << 6));
		apb(1'b0, 5'd5, 32'h0);
		chk_reg(d, 32'h0080);
		apb(1'b0, 5'd6, 32'h0);
		chk_reg(d & 32'h11, 32'h0);
		$display("test parallel 100 done");
		mode <= 2'd2;
		restart(32'h3200);
		wait_up();
		chk_reg({link_up, speed_100, full_duplex}, 3'b100);
		apb(1'b0, 5'd5, 32'h0);
		chk_reg(d, 32'h0020);
		$display("test restart 10 done");
		mode <= 2'd3;
		for (i = 0; i < 5; i++)
		begin
			a = (i == 4) ? 15 : $urandom_range(15, 0);
			p = (i == 4) ? 15 : $urandom_range(15, 0);
			x = link_up;
			apb(1'b1, 5'd4, (a << 5) | 32'h1);
			repeat (2) @(posedge pclk);
			chk_bit(link_up | traffic_halt, x[0]);
			restart(32'h1200 | ($urandom_range(1, 0) << 13) | ($urandom_range(1, 0) << 8));
			word <= (p << 5) | 16'h1;
			send <= 1'b1;
			@(posedge pclk);
			send <= 1'b0;
			repeat (4) @(posedge pclk);
			c = a & p;
			chk_bit(link_up, c != 0);
			if (c != 0) chk_bit(speed_100, c >= 4);
			if (c != 0) chk_bit(full_duplex, c[3] | (c < 4 & c[1]));
			apb(1'b0, 5'd5, 32'h0);
			chk_reg(d, (p << 5) | 32'h1);
		end
		crs_check(1'b1);
		cut <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_bit(link_up, 1'b0);
		apb(1'b0, 5'd1, 32'h0);
		chk_reg(d & 32'h31, 32'h20);
		pd_fault_in <= 1'b1;
		@(posedge pclk);
		pd_fault_in <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 5'd6, 32'h0);
		chk_reg(d & 32'h11, 32'h11);
		apb(1'b0, 5'd6, 32'h0);
		chk_reg(d & 32'h10, 32'h0);
		$display("test negotiate done");
		cut  <= 1'b0;
		mode <= 2'd1;
		wait_up();
		apb(1'b0, 5'd6, 32'h0);
		chk_reg(d & 32'h1, 32'h0);
		mode <= 2'd3;
		$display("test legacy after negotiation done");
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, 5'd0, (i[1] << 13) | (i[0] << 8));
			repeat (3) @(posedge pclk);
			chk_reg({link_up, speed_100, full_duplex}, {1'b1, i[1], i[0]});
			crs_check(i[0]);
			apb(1'b0, 5'd1, 32'h0);
			chk_reg(d & 32'h30, 32'h0);
		end
		for (i = 0; i < 16; i++)
		begin
			apb(1'b1, 5'd27, i[3] ? 32'h8000 : 32'h0);
			crossover_enable_pin <= i[2];
			partner_crossed      <= i[1];
			pair_swap_select_pin <= i[0];
			repeat (3) @(posedge pclk);
			chk_bit(twisted_pair_swap, (i[3] & i[2]) ? i[1] : i[0]);
		end
		apb(1'b1, 5'd0, 32'h1000);
		repeat (2) @(posedge pclk);
		apb(1'b0, 5'd1, 32'h0);
		chk_reg(d & 32'h30, 32'h20);
		$display("test forced done");
		report_and_stop();
	end
endmodule : phy_link_mode_control_tb_top

`default_nettype wire
